// File: rtl/clk_sleep_cfg.svh
// Register indexes, field positions, reset values and counts of the clock and sleep block.
`ifndef CLK_SLEEP_CFG_SVH
`define CLK_SLEEP_CFG_SVH
`define OSC_MAIN_IDX 12'h0E0
`define XCFG_IDX 12'h0E1
`define SYSCFG_IDX 12'h0F0
`define STATUS_IDX 12'h0F1
`define OSC_MAIN_RST 8'h02
`define XCFG_RST 8'h00
`define SYSCFG_RST 8'h00
`define XCFG_LPM_BIT 2
`define XCFG_WR_BIT 1
`define XCFG_PRES_BIT 0
`define SYS_EXT_BIT 2
`define ST_XTAL_BIT 0
`define ST_BGAP_BIT 1
`define ST_BUZZ_BIT 2
`define ST_SLEEP_BIT 3
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define BUZZ_TICKS 16'h0020
`define SLEEP_PERIOD0 16'h0040
`define SLEEP_PERIOD1 16'h0200
`define SLEEP_PERIOD2 16'h1000
`define SLEEP_PERIOD3 16'h8000
`endif

// File: rtl/clk_sleep_pkg.sv
// Types shared by the clock and sleep configuration block.
package clk_sleep_pkg;
  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;
  typedef struct packed {
    logic crystal_select;
    logic pulse_off;
    logic keep_on;
    logic [1:0] sleep_sel;
    logic [2:0] cpu_div;
  } osc_main_t;
  typedef enum logic [1:0] {RATE_12M = 2'b00, RATE_6M = 2'b01, RATE_24M = 2'b10} sys_rate_t;
  typedef enum logic [1:0] {WR_COLLECT = 2'b01, WR_RESP = 2'b10} wr_state_t;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} rd_state_t;
endpackage

// File: rtl/cpu_clk_divider.sv
// Divider that turns the system clock into a one-cycle CPU clock tick.
`timescale 1ns/1ps
module cpu_clk_divider #(
  parameter int CNT_W = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [2:0] i_div_sel,
  output logic o_cpu_tick
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  // Divide ratio minus one for each setting of the divider field.
  function automatic logic [CNT_W-1:0] last_count(input logic [2:0] sel);
    case (sel)
      3'b000: last_count = CNT_W'(8'h07);
      3'b001: last_count = CNT_W'(8'h03);
      3'b010: last_count = CNT_W'(8'h01);
      3'b011: last_count = CNT_W'(8'h00);
      3'b100: last_count = CNT_W'(8'h0F);
      3'b101: last_count = CNT_W'(8'h1F);
      3'b110: last_count = CNT_W'(8'h7F);
      default: last_count = CNT_W'(8'hFF);
    endcase
  endfunction

  // A greater-or-equal wrap keeps a shrinking ratio from running the count past its end.
  always_comb begin
    tick_d = (cnt_q >= last_count(i_div_sel));
    cnt_d = tick_d ? '0 : cnt_q + CNT_W'(1);
  end

  // Count register and tick flop.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign o_cpu_tick = tick_q;

  chk_div_unity: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (o_cpu_tick && i_div_sel == 3'b011) |=> o_cpu_tick)
    else $error("CPU tick missing at divide by one.");

  chk_div_half: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (o_cpu_tick && i_div_sel == 3'b010) ##1 (i_div_sel == 3'b010)
    |-> !o_cpu_tick ##1 (i_div_sel != 3'b010 || o_cpu_tick))
    else $error("CPU tick spacing wrong at divide by two.");
endmodule

// File: rtl/sleep_timer.sv
// Sleep interval timer counting ticks of the selected 32 kHz clock.
`timescale 1ns/1ps
`include "clk_sleep_cfg.svh"
module sleep_timer #(
  parameter int CNT_W = 16,
  parameter logic [CNT_W-1:0] PERIOD0 = `SLEEP_PERIOD0,
  parameter logic [CNT_W-1:0] PERIOD1 = `SLEEP_PERIOD1,
  parameter logic [CNT_W-1:0] PERIOD2 = `SLEEP_PERIOD2,
  parameter logic [CNT_W-1:0] PERIOD3 = `SLEEP_PERIOD3
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [1:0] i_sel,
  input wire logic i_tick,
  output logic o_wake
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic wake_q;
  logic wake_d;
  logic [CNT_W-1:0] last0;

  // Last count of one interval for each setting.
  function automatic logic [CNT_W-1:0] last_of(input logic [1:0] sel);
    case (sel)
      2'b00: last_of = PERIOD0 - CNT_W'(1);
      2'b01: last_of = PERIOD1 - CNT_W'(1);
      2'b10: last_of = PERIOD2 - CNT_W'(1);
      default: last_of = PERIOD3 - CNT_W'(1);
    endcase
  endfunction

  assign last0 = last_of(2'b00);

  // The count only moves on a tick, so a wake is a whole number of 32 kHz periods apart.
  always_comb begin
    wake_d = i_tick && (cnt_q >= last_of(i_sel));
    cnt_d = cnt_q;
    if (wake_d) begin
      cnt_d = '0;
    end else if (i_tick) begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end

  // Count register and wake flop.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= '0;
      wake_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      wake_q <= wake_d;
    end
  end

  assign o_wake = wake_q;

  chk_wake_period: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_tick && i_sel == 2'b00 && cnt_q == last0) |=> o_wake ##1 (cnt_q == '0 || !o_wake))
    else $error("Sleep wake missing at end of interval.");

  chk_wake_cause: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    o_wake |-> $past(i_tick) && cnt_q == '0)
    else $error("Sleep wake without a tick.");
endmodule

// File: rtl/clock_source_sleep_config.sv
// Clock source, bandgap sleep and CPU divider configuration behind an AXI4-Lite slave.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "clk_sleep_cfg.svh"
module clock_source_sleep_config
  import clk_sleep_pkg::*;
#(
  parameter logic [15:0] BUZZ_TICKS = `BUZZ_TICKS
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire axi_req_t i_axi,
  output axi_rsp_t o_axi,
  input wire logic i_sleep,
  input wire logic i_intosc_tick,
  input wire logic i_xtal_tick,
  output logic o_clk32_tick,
  output logic o_clk32_src,
  output logic o_crystal_low_power,
  output logic o_bandgap_on,
  output logic o_sleep_wake,
  output logic o_cpu_tick,
  output sys_rate_t o_sys_rate,
  output logic o_sys_ext
);
  wr_state_t wr_q, wr_d;
  rd_state_t rd_q, rd_d;
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [11:0] aw_addr_q, aw_addr_d;
  logic [7:0] w_data_q, w_data_d;
  logic w_lane0_q, w_lane0_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_commit, aw_take, w_take, ar_take;
  osc_main_t osc_q, osc_d;
  logic [7:0] xcfg_q, xcfg_d, sys_q, sys_d;
  logic src_q, src_d, tick32_q, tick32_d, bgap_q, bgap_d, buzz_q, buzz_d;
  logic [15:0] buzz_cnt_q, buzz_cnt_d;
  logic buzz_allowed;

  // Register index of a byte address; the low two bits must be zero for a hit.
  function automatic logic [11:0] idx_of(input logic [11:0] addr);
    idx_of = {2'b00, addr[11:2]};
  endfunction

  // True when an address lands on one of the four register words.
  function automatic logic is_mapped(input logic [11:0] addr);
    logic [11:0] idx;
    idx = idx_of(addr);
    is_mapped = (addr[1:0] == 2'b00) && (idx == `OSC_MAIN_IDX || idx == `XCFG_IDX ||
                idx == `SYSCFG_IDX || idx == `STATUS_IDX);
  endfunction

  // Status word showing the live source, bandgap and sleep state; the buzz bit shows whether the written bits allow buzzing.
  function automatic logic [7:0] status_word(input logic src, input logic bgap,
                                             input logic buzz, input logic sleep);
    status_word = 8'h00;
    status_word[`ST_XTAL_BIT] = src;
    status_word[`ST_BGAP_BIT] = bgap;
    status_word[`ST_BUZZ_BIT] = buzz;
    status_word[`ST_SLEEP_BIT] = sleep;
  endfunction

  // Handshake readies come straight from state so the master sees them early.
  assign aw_take = i_axi.awvalid && o_axi.awready;
  assign w_take = i_axi.wvalid && o_axi.wready;
  assign ar_take = i_axi.arvalid && o_axi.arready;
  assign wr_commit = (wr_q == WR_COLLECT) && aw_hold_q && w_hold_q;
  always_comb begin
    o_axi = '0;
    o_axi.awready = (wr_q == WR_COLLECT) && !aw_hold_q;
    o_axi.wready = (wr_q == WR_COLLECT) && !w_hold_q;
    o_axi.bvalid = (wr_q == WR_RESP);
    o_axi.bresp = bresp_q;
    o_axi.arready = (rd_q == RD_IDLE);
    o_axi.rvalid = (rd_q == RD_DATA);
    o_axi.rdata = rdata_q;
    o_axi.rresp = rresp_q;
  end

  // Write channel: address and data are held in either order, committed together.
  always_comb begin
    wr_d = wr_q;
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    aw_addr_d = aw_addr_q;
    w_data_d = w_data_q;
    w_lane0_d = w_lane0_q;
    bresp_d = bresp_q;
    case (wr_q)
      WR_COLLECT: begin
        if (aw_take) begin
          aw_hold_d = 1'b1;
          aw_addr_d = i_axi.awaddr;
        end
        if (w_take) begin
          w_hold_d = 1'b1;
          w_data_d = i_axi.wdata[7:0];
          w_lane0_d = i_axi.wstrb[0];
        end
        if (wr_commit) begin
          bresp_d = is_mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
          wr_d = WR_RESP;
        end
      end
      WR_RESP: begin
        if (i_axi.bready) begin
          aw_hold_d = 1'b0;
          w_hold_d = 1'b0;
          wr_d = WR_COLLECT;
        end
      end
      default: wr_d = WR_COLLECT;
    endcase
  end

  // Read channel: data is sampled at the address handshake, answered the next cycle.
  always_comb begin
    rd_d = rd_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    case (rd_q)
      RD_IDLE: begin
        if (ar_take) begin
          rd_d = RD_DATA;
          rdata_d = 32'h0000_0000;
          rresp_d = is_mapped(i_axi.araddr) ? `RESP_OKAY : `RESP_SLVERR;
          case (idx_of(i_axi.araddr))
            `OSC_MAIN_IDX: rdata_d[7:0] = osc_q;
            `XCFG_IDX: rdata_d[7:0] = xcfg_q;
            `SYSCFG_IDX: rdata_d[7:0] = sys_q;
            `STATUS_IDX: rdata_d[7:0] = status_word(src_q, bgap_q, buzz_allowed, i_sleep);
            default: rdata_d = 32'h0000_0000;
          endcase
          if (i_axi.araddr[1:0] != 2'b00) begin
            rdata_d = 32'h0000_0000;
          end
        end
      end
      RD_DATA: begin
        if (i_axi.rready) begin
          rd_d = RD_IDLE;
        end
      end
      default: rd_d = RD_IDLE;
    endcase
  end

  // Register file. Only byte lane 0 carries data; the crystal word locks after one write.
  always_comb begin
    osc_d = osc_q;
    xcfg_d = xcfg_q;
    sys_d = sys_q;
    if (wr_commit && w_lane0_q && aw_addr_q[1:0] == 2'b00) begin
      case (idx_of(aw_addr_q))
        `OSC_MAIN_IDX: osc_d = osc_main_t'(w_data_q);
        `XCFG_IDX: begin
          if (!xcfg_q[`XCFG_WR_BIT]) begin
            xcfg_d = 8'h00;
            xcfg_d[`XCFG_LPM_BIT] = w_data_q[`XCFG_LPM_BIT];
            xcfg_d[`XCFG_PRES_BIT] = w_data_q[`XCFG_PRES_BIT];
            xcfg_d[`XCFG_WR_BIT] = 1'b1;
          end
        end
        `SYSCFG_IDX: begin
          sys_d = w_data_q & 8'h07;
          if (w_data_q[1:0] == 2'b11) begin
            sys_d[1:0] = RATE_12M;
          end
        end
        default: sys_d = sys_q;
      endcase
    end
  end

  // Source selection and bandgap control. The crystal needs both the select and the
  // present flag, so a board without one can never lose its 32 kHz clock.
  assign buzz_allowed = !osc_q.keep_on && !osc_q.pulse_off;
  always_comb begin
    src_d = osc_q.crystal_select && xcfg_q[`XCFG_PRES_BIT];
    tick32_d = src_q ? i_xtal_tick : i_intosc_tick;
    bgap_d = !i_sleep || osc_q.keep_on || (!osc_q.pulse_off && buzz_q);
    buzz_cnt_d = '0;
    buzz_d = 1'b0;
    if (i_sleep && buzz_allowed) begin
      buzz_cnt_d = buzz_cnt_q;
      if (tick32_q) begin
        buzz_d = (buzz_cnt_q >= BUZZ_TICKS - 16'h0001);
        buzz_cnt_d = buzz_d ? 16'h0000 : buzz_cnt_q + 16'h0001;
      end
    end
  end

  // All state of the block except that inside the divider and sleep timer instances registers here.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_q <= WR_COLLECT;
      rd_q <= RD_IDLE;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 8'h00;
      w_lane0_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      rresp_q <= `RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      osc_q <= osc_main_t'(`OSC_MAIN_RST);
      xcfg_q <= `XCFG_RST;
      sys_q <= `SYSCFG_RST;
      src_q <= 1'b0;
      tick32_q <= 1'b0;
      bgap_q <= 1'b1;
      buzz_q <= 1'b0;
      buzz_cnt_q <= 16'h0000;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_lane0_q <= w_lane0_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      osc_q <= osc_d;
      xcfg_q <= xcfg_d;
      sys_q <= sys_d;
      src_q <= src_d;
      tick32_q <= tick32_d;
      bgap_q <= bgap_d;
      buzz_q <= buzz_d;
      buzz_cnt_q <= buzz_cnt_d;
    end
  end

  // CPU clock divider fed from the live divider field.
  cpu_clk_divider #(
    .CNT_W(8)
  ) u_div (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_div_sel(osc_q.cpu_div),
    .o_cpu_tick(o_cpu_tick)
  );

  // Sleep interval timer running on the selected 32 kHz tick.
  sleep_timer #(
    .CNT_W(16)
  ) u_sleep (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_sel(osc_q.sleep_sel),
    .i_tick(tick32_q),
    .o_wake(o_sleep_wake)
  );

  assign o_clk32_tick = tick32_q;
  assign o_clk32_src = src_q;
  assign o_crystal_low_power = xcfg_q[`XCFG_LPM_BIT];
  assign o_bandgap_on = bgap_q;
  assign o_sys_rate = sys_rate_t'(sys_q[1:0]);
  assign o_sys_ext = sys_q[`SYS_EXT_BIT];

  chk_xtal_blocked: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    !xcfg_q[`XCFG_PRES_BIT] |=> !o_clk32_src)
    else $error("Crystal selected while not present.");

  chk_xtal_follows: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (xcfg_q[`XCFG_PRES_BIT] && osc_q.crystal_select) |=> o_clk32_src ##1
    (o_clk32_tick == $past(i_xtal_tick)))
    else $error("Crystal source not taken when present and selected.");

  chk_intosc_tick: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    !o_clk32_src |=> (o_clk32_tick == $past(i_intosc_tick)))
    else $error("Internal oscillator tick not passed through.");

  chk_keep_on: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (osc_q.keep_on && osc_q.pulse_off) |=> o_bandgap_on)
    else $error("Bandgap off while keep-on is set.");

  chk_pulse_off: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_sleep && osc_q.pulse_off && !osc_q.keep_on) |=> !o_bandgap_on)
    else $error("Bandgap powered in sleep with pulses off.");

  chk_buzz_wake: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_sleep && buzz_allowed && buzz_q) |=> o_bandgap_on)
    else $error("Bandgap buzz pulse lost.");

  chk_lock_hold: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    xcfg_q[`XCFG_WR_BIT] |=> $stable(xcfg_q) && xcfg_q[`XCFG_WR_BIT])
    else $error("Crystal configuration changed after lock.");

  chk_flag_set: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (wr_commit && w_lane0_q && aw_addr_q[1:0] == 2'b00 && idx_of(aw_addr_q) == `XCFG_IDX)
    |=> xcfg_q[`XCFG_WR_BIT])
    else $error("Written flag not set by crystal write.");

  chk_div_reset: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    !$past(i_resetn) |-> (osc_q.cpu_div == 3'b010 && o_sys_rate == RATE_12M))
    else $error("Divider or system rate wrong after reset.");

  chk_bresp_hold: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (o_axi.bvalid && !i_axi.bready) |=> o_axi.bvalid && $stable(o_axi.bresp))
    else $error("Write response dropped before ready.");
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the clock source and sleep configuration block.
`timescale 1ns/1ps
`include "clk_sleep_cfg.svh"
module tb_top
  import clk_sleep_pkg::*;
;
  localparam logic [11:0] A_OSC = `OSC_MAIN_IDX << 2;
  localparam logic [11:0] A_XCFG = `XCFG_IDX << 2;
  localparam logic [11:0] A_SYS = `SYSCFG_IDX << 2;
  localparam logic [11:0] A_STAT = `STATUS_IDX << 2;
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  axi_req_t req = '0;
  axi_rsp_t rsp;
  logic i_sleep = 1'b0;
  logic i_intosc_tick = 1'b0;
  logic i_xtal_tick = 1'b0;
  logic o_clk32_tick, o_clk32_src, o_crystal_low_power, o_bandgap_on;
  logic o_sleep_wake, o_cpu_tick, o_sys_ext;
  sys_rate_t o_sys_rate;
  logic [1:0] ph_q = 2'd0;
  logic intosc_d = 1'b0;
  logic xtal_d = 1'b0;
  logic mon_en = 1'b0;
  logic mon_src = 1'b0;
  int num_errors = 0;
  int samples_checked = 0;
  logic [31:0] d;
  logic [1:0] r;
  int c;
  int div_tab [8] = '{8, 4, 2, 1, 16, 32, 128, 256};
  logic [7:0] bg_mode [4] = '{8'h20, 8'h60, 8'h40, 8'h00};
  int bg_exp [4] = '{160, 160, 0, 10};

  // A small buzz count keeps the bandgap pulse spacing short enough to count.
  clock_source_sleep_config #(.BUZZ_TICKS(16'h0004)) DUT (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_axi(req),
    .o_axi(rsp),
    .i_sleep(i_sleep),
    .i_intosc_tick(i_intosc_tick),
    .i_xtal_tick(i_xtal_tick),
    .o_clk32_tick(o_clk32_tick),
    .o_clk32_src(o_clk32_src),
    .o_crystal_low_power(o_crystal_low_power),
    .o_bandgap_on(o_bandgap_on),
    .o_sleep_wake(o_sleep_wake),
    .o_cpu_tick(o_cpu_tick),
    .o_sys_rate(o_sys_rate),
    .o_sys_ext(o_sys_ext)
  );

  // Clock at 50 ns.
  always #25 i_ref_clk = ~i_ref_clk;

  // Both slow ticks run every four cycles at different phases, so a wrong source shows.
  always @(posedge i_ref_clk) begin
    ph_q <= ph_q + 2'd1;
    i_intosc_tick <= (ph_q == 2'd3);
    i_xtal_tick <= (ph_q == 2'd1);
    intosc_d <= i_intosc_tick;
    xtal_d <= i_xtal_tick;
  end

  // The selected tick must follow its source one cycle later.
  always @(negedge i_ref_clk) begin
    if (mon_en) begin
      check(32'(o_clk32_tick), 32'(mon_src ? xtal_d : intosc_d));
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic timed_out();
    num_errors++;
    $display("Error at %0t: wait limit reached", $time);
    give_verdict();
  endtask

  // Handshakes are judged on values settled before the edge that takes them.
  task automatic wr(input logic [11:0] a, input logic [31:0] wd, output logic [1:0] rs);
    logic haw, hw, hb, bv, done;
    int n;
    done = 1'b0;
    @(posedge i_ref_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= wd;
    req.wstrb <= 4'h1;
    for (n = 0; n < 50 && !done; n++) begin
      #1;
      haw = req.awvalid && rsp.awready;
      hw = req.wvalid && rsp.wready;
      hb = rsp.bvalid && req.bready;
      bv = rsp.bvalid;
      rs = rsp.bresp;
      @(posedge i_ref_clk);
      if (haw) req.awvalid <= 1'b0;
      if (hw) req.wvalid <= 1'b0;
      if (hb) begin
        req.bready <= 1'b0;
        done = 1'b1;
      end else if (bv) begin
        req.bready <= 1'b1; // A late ready makes the slave hold its response for a cycle.
      end
    end
    if (!done) timed_out();
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] rdv, output logic [1:0] rs);
    logic har, hr, done;
    int n;
    done = 1'b0;
    @(posedge i_ref_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (n = 0; n < 50 && !done; n++) begin
      #1;
      har = req.arvalid && rsp.arready;
      hr = rsp.rvalid && req.rready;
      rdv = rsp.rdata;
      rs = rsp.rresp;
      @(posedge i_ref_clk);
      if (har) req.arvalid <= 1'b0;
      if (hr) begin
        req.rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) timed_out();
  endtask

  // Cycles between the second and third pulse of the CPU tick (0) or the wake (1).
  task automatic gap(input int which, output int cyc);
    int n, k;
    k = 0;
    cyc = 0;
    for (n = 0; n < 8000 && k < 3; n++) begin
      @(negedge i_ref_clk);
      if (k == 2) cyc++;
      if (((which == 0) ? o_cpu_tick : o_sleep_wake) === 1'b1) k++;
    end
    if (k < 3) timed_out();
  endtask

  task automatic settle();
    repeat (4) @(negedge i_ref_clk);
  endtask

  // Main sequence.
  initial begin
    repeat (19) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    check(32'(o_bandgap_on), 32'h0000_0001);
    @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    rd(A_OSC, d, r);
    check(d, 32'h0000_0002);
    rd(A_XCFG, d, r);
    check(d, 32'h0000_0000);
    rd(A_SYS, d, r);
    check(d, 32'h0000_0000);
    check(32'(o_sys_rate), 32'(RATE_12M));
    rd(A_OSC + 12'h001, d, r);
    check(32'(r), 32'(`RESP_SLVERR));
    check(d, 32'h0000_0000);
    rd(12'h000, d, r);
    check(32'(r), 32'(`RESP_SLVERR));
    check(d, 32'h0000_0000);
    wr(12'h004, 32'h0000_00ff, r);
    check(32'(r), 32'(`RESP_SLVERR));
    // Every divider code, measured on the CPU tick spacing.
    for (int i = 0; i < 8; i++) begin
      wr(A_OSC, 32'(i), r);
      gap(0, c);
      check(32'(c), 32'(div_tab[i]));
    end
    wr(A_SYS, 32'h0000_0002, r);
    settle();
    check(32'(o_sys_rate), 32'(RATE_24M));
    wr(A_SYS, 32'h0000_0001, r);
    settle();
    check(32'(o_sys_rate), 32'(RATE_6M));
    wr(A_SYS, 32'h0000_0004, r);
    settle();
    check(32'(o_sys_ext), 32'h0000_0001);
    check(32'(o_sys_rate), 32'(RATE_12M));
    wr(A_SYS, 32'h0000_0003, r);
    settle();
    check(32'(o_sys_rate), 32'(RATE_12M));
    check(32'(o_sys_ext), 32'h0000_0000);
    // Selecting the crystal before it is declared present must not move the source.
    wr(A_OSC, 32'h0000_0083, r);
    settle();
    check(32'(o_clk32_src), 32'h0000_0000);
    mon_src = 1'b0;
    mon_en = 1'b1;
    repeat (20) @(negedge i_ref_clk);
    mon_en = 1'b0;
    wr(A_XCFG, 32'h0000_0005, r);
    check(32'(r), 32'(`RESP_OKAY));
    rd(A_XCFG, d, r);
    check(d, 32'h0000_0007);
    settle();
    check(32'(o_crystal_low_power), 32'h0000_0001);
    check(32'(o_clk32_src), 32'h0000_0001);
    mon_src = 1'b1;
    mon_en = 1'b1;
    repeat (20) @(negedge i_ref_clk);
    mon_en = 1'b0;
    rd(A_STAT, d, r);
    check(32'(d[0]), 32'h0000_0001);
    // The word is locked after its first write.
    wr(A_XCFG, 32'h0000_0000, r);
    rd(A_XCFG, d, r);
    check(d, 32'h0000_0007);
    wr(A_OSC, 32'h0000_0003, r);
    settle();
    check(32'(o_clk32_src), 32'h0000_0000);
    mon_src = 1'b0;
    mon_en = 1'b1;
    repeat (20) @(negedge i_ref_clk);
    mon_en = 1'b0;
    // Bandgap in sleep: keep-on, both bits, pulse-off alone, plain buzzing.
    @(posedge i_ref_clk);
    i_sleep <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(A_OSC, 32'(bg_mode[i] | 8'h03), r);
      repeat (20) @(negedge i_ref_clk);
      c = 0;
      repeat (160) begin
        @(negedge i_ref_clk);
        if (o_bandgap_on === 1'b1) c++;
      end
      if (i < 3) check(32'(c), 32'(bg_exp[i]));
      else check(32'(c >= bg_exp[i] - 1 && c <= bg_exp[i] + 1), 32'h0000_0001);
    end
    rd(A_STAT, d, r);
    check(32'(d[3]), 32'h0000_0001);
    check(32'(d[2]), 32'h0000_0001);
    // Sleep intervals for the two shortest settings.
    wr(A_OSC, 32'h0000_0023, r);
    gap(1, c);
    check(32'(c), 32'(`SLEEP_PERIOD0) * 4);
    wr(A_OSC, 32'h0000_002b, r);
    gap(1, c);
    check(32'(c), 32'(`SLEEP_PERIOD1) * 4);
    @(posedge i_ref_clk);
    i_sleep <= 1'b0;
    settle();
    check(32'(o_bandgap_on), 32'h0000_0001);
    // A fresh reset clears the written flag and the lock.
    @(posedge i_ref_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    rd(A_XCFG, d, r);
    check(d, 32'h0000_0000);
    wr(A_XCFG, 32'h0000_0001, r);
    rd(A_XCFG, d, r);
    check(d, 32'h0000_0003);
    give_verdict();
  end
endmodule
